// File: design/fhrr_defines.vh
// Purpose: Constants of the FSK receive frame handler
// Assumes: 32-bit register bus, word-aligned byte offsets
// Notes: Definitions only
`ifndef FHRR_DEFINES_VH
`define FHRR_DEFINES_VH

// Register byte offsets
`define FHRR_OFS_CTRL 8'h00
`define FHRR_OFS_RAW_LEN 8'h04
`define FHRR_OFS_ON_DUR 8'h08
`define FHRR_OFS_OFF_DUR 8'h0C
`define FHRR_OFS_STATUS 8'h10
`define FHRR_OFS_RX_LEN 8'h14
`define FHRR_OFS_ENERGY 8'h18
`define FHRR_OFS_STATE 8'h1C

// Control register fields
`define FHRR_CTRL_MODE_DET 0
`define FHRR_CTRL_CAPT_LSB 1
`define FHRR_CTRL_DUTY_EN 3
`define FHRR_CTRL_BITORD 4
`define FHRR_CTRL_TBASE_LSB 5
`define FHRR_CTRL_RX_EN 8
`define FHRR_CTRL_PDT_LSB 16
`define FHRR_CTRL_MASK 32'h00FF01FF
`define FHRR_CTRL_RESET 32'h00400004
`define FHRR_DUR_RESET 8'h01

// Header bit positions, first received bit is index 0
`define FHRR_PHR_MODE 0
`define FHRR_PHR_RSV1 1
`define FHRR_PHR_RSV2 2
`define FHRR_PHR_FCS_TYPE 3
`define FHRR_PHR_WHITEN 4
`define FHRR_PHR_LEN_LSB 5
`define FHRR_PHR_BITS 16

// Override threshold step and disable code
`define FHRR_CAPT_STEP_DB 9'h006
`define FHRR_CAPT_OFF 2'h3

// De-whitening sequence seed
`define FHRR_PN9_SEED 9'h1FF

// Duty-cycle base time unit
`define FHRR_BASE_TIME_NS 1000
`define FHRR_CLK_MHZ 125
`define FHRR_BASE_CYC ((`FHRR_BASE_TIME_NS * `FHRR_CLK_MHZ) / 1000)

`endif

// File: design/fhrr_rx_frame.v
// Purpose: FSK receive frame handling, override, duty-cycled listening, AHB-Lite registers
// Assumes: Demodulator and frame buffer run on ref_clk; rssi_dbm is signed dBm
// Notes: Register offsets and fields live in the defines header
//
// The address map and register access over AHB-Lite were decided locally.
`include "fhrr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module fhrr_rx_frame #(
   parameter LEN_W = 11,
   parameter BASE_CYC = `FHRR_BASE_CYC
) (
   input wire ref_clk,
   input wire rst,
   input wire ce,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire sync_done,
   input wire sync_raw,
   input wire sync_fec,
   input wire bit_valid,
   input wire bit_data,
   input wire [7:0] corr_val,
   input wire [7:0] rssi_dbm,
   output reg fb_wr_en,
   output reg [LEN_W-1:0] fb_wr_addr,
   output reg [7:0] fb_wr_data,
   output reg frame_start_irq,
   output reg frame_end,
   output reg listen_restart,
   output wire frontend_on,
   output wire preamble_lock,
   output wire rx_state_active,
   output reg dewhite_active,
   output reg fcs_eval_en,
   output reg addr_filter_en,
   output reg fec_active
);

   localparam S_IDLE = 3'd0;
   localparam S_LISTEN = 3'd1;
   localparam S_LOCK = 3'd2;
   localparam S_HDR = 3'd3;
   localparam S_MSW = 3'd4;
   localparam S_DATA = 3'd5;

   reg [2:0] state_reg;
   reg [31:0] ctrl_reg;
   reg [LEN_W-1:0] raw_len_reg;
   reg [7:0] on_dur_reg;
   reg [7:0] off_dur_reg;
   reg mode_switch_flag;
   reg reserved_bit_first;
   reg reserved_bit_second;
   reg fcs_type_status;
   reg whitening_flag;
   reg [LEN_W-1:0] rx_len_reg;
   reg [7:0] frame_energy_value;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg [15:0] hdr_reg;
   reg [4:0] hdr_cnt_reg;
   reg [7:0] oct_reg;
   reg [2:0] oct_bit_reg;
   reg [LEN_W-1:0] oct_cnt_reg;
   reg [LEN_W-1:0] len_reg;
   reg raw_frame_reg;
   reg [8:0] pn9_reg;
   reg [7:0] rssi_ref_reg;
   reg phase_on_reg;
   reg [7:0] duty_cnt_reg;
   reg [15:0] presc_reg;
   reg [31:0] rd_next;

   wire mode_switch_detect_enable = ctrl_reg[`FHRR_CTRL_MODE_DET];
   wire [1:0] capture_restart_level = ctrl_reg[`FHRR_CTRL_CAPT_LSB+1:`FHRR_CTRL_CAPT_LSB];
   wire duty_cycle_switch = ctrl_reg[`FHRR_CTRL_DUTY_EN];
   wire raw_bit_order_select = ctrl_reg[`FHRR_CTRL_BITORD];
   wire [2:0] duty_base_time = ctrl_reg[`FHRR_CTRL_TBASE_LSB+2:`FHRR_CTRL_TBASE_LSB];
   wire rx_enable = ctrl_reg[`FHRR_CTRL_RX_EN];
   wire [7:0] preamble_thr = ctrl_reg[`FHRR_CTRL_PDT_LSB+7:`FHRR_CTRL_PDT_LSB];

   // Header word including the bit arriving now
   wire [15:0] hdr_full = {bit_data, hdr_reg[14:0]};
   wire [LEN_W-1:0] phr_len;
   wire dbit = bit_data ^ (dewhite_active & pn9_reg[0]);
   wire [7:0] oct_fill = oct_reg | ({7'h00, dbit} << oct_bit_reg);
   wire [7:0] oct_rev;
   wire [7:0] msw_oct = (oct_cnt_reg == {LEN_W{1'b0}}) ? hdr_reg[7:0] : hdr_reg[15:8];
   wire [7:0] msw_rev;

   // Length field is sent most significant bit first
   genvar gi;
   generate
      for (gi = 0; gi < LEN_W; gi = gi + 1) begin : g_len
         assign phr_len[LEN_W-1-gi] = hdr_full[`FHRR_PHR_LEN_LSB+gi];
      end
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
         assign oct_rev[gi] = oct_fill[7-gi];
         assign msw_rev[gi] = msw_oct[7-gi];
      end
   endgenerate

   wire in_frame = (state_reg == S_LOCK) || (state_reg == S_HDR) ||
                   (state_reg == S_MSW) || (state_reg == S_DATA);
   // Signed rise of strength since lock, against 6/12/18 dB steps
   wire signed [8:0] rssi_rise = $signed({rssi_dbm[7], rssi_dbm}) -
                                 $signed({rssi_ref_reg[7], rssi_ref_reg});
   wire [8:0] capt_thr = `FHRR_CAPT_STEP_DB * ({7'h00, capture_restart_level} + 9'h001);
   wire capt_hit = in_frame && (capture_restart_level != `FHRR_CAPT_OFF) &&
                   (rssi_rise > $signed(capt_thr));

   assign frontend_on = !(duty_cycle_switch && state_reg == S_LISTEN && !phase_on_reg);
   assign preamble_lock = in_frame;
   assign rx_state_active = (state_reg != S_IDLE);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire [15:0] tick_len = BASE_CYC[15:0] << duty_base_time;
   wire addr_ph = hsel && htrans[1] && hready;

   always @* begin
      rd_next = 32'h00000000;
      if (haddr[7:0] == `FHRR_OFS_CTRL) begin
         rd_next = ctrl_reg;
      end else if (haddr[7:0] == `FHRR_OFS_RAW_LEN) begin
         rd_next[LEN_W-1:0] = raw_len_reg;
      end else if (haddr[7:0] == `FHRR_OFS_ON_DUR) begin
         rd_next[7:0] = on_dur_reg;
      end else if (haddr[7:0] == `FHRR_OFS_OFF_DUR) begin
         rd_next[7:0] = off_dur_reg;
      end else if (haddr[7:0] == `FHRR_OFS_STATUS) begin
         rd_next[4:0] = {whitening_flag, fcs_type_status, reserved_bit_second,
                         reserved_bit_first, mode_switch_flag};
      end else if (haddr[7:0] == `FHRR_OFS_RX_LEN) begin
         rd_next[LEN_W-1:0] = rx_len_reg;
      end else if (haddr[7:0] == `FHRR_OFS_ENERGY) begin
         rd_next[7:0] = frame_energy_value;
      end else if (haddr[7:0] == `FHRR_OFS_STATE) begin
         rd_next[5:0] = {fec_active, raw_frame_reg, phase_on_reg, preamble_lock,
                         rx_state_active, frontend_on};
      end
   end

   // Register bus: zero wait states, read data registered at address phase
   always @(posedge ref_clk) begin
      if (rst) begin
         hrdata <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         ctrl_reg <= `FHRR_CTRL_RESET;
         raw_len_reg <= {LEN_W{1'b0}};
         on_dur_reg <= `FHRR_DUR_RESET;
         off_dur_reg <= `FHRR_DUR_RESET;
      end else if (ce) begin
         if (hready) begin
            wr_pend_reg <= addr_ph && hwrite;
            wr_addr_reg <= haddr[7:0];
         end
         if (addr_ph && !hwrite) begin
            hrdata <= rd_next;
         end
         if (wr_pend_reg) begin
            if (wr_addr_reg == `FHRR_OFS_CTRL) begin
               ctrl_reg <= hwdata & `FHRR_CTRL_MASK;
            end else if (wr_addr_reg == `FHRR_OFS_RAW_LEN) begin
               raw_len_reg <= hwdata[LEN_W-1:0];
            end else if (wr_addr_reg == `FHRR_OFS_ON_DUR) begin
               on_dur_reg <= hwdata[7:0];
            end else if (wr_addr_reg == `FHRR_OFS_OFF_DUR) begin
               off_dur_reg <= hwdata[7:0];
            end
         end
      end
   end

   // Duty cycle runs only while listening; any other state re-arms it
   always @(posedge ref_clk) begin
      if (rst) begin
         phase_on_reg <= 1'b1;
         duty_cnt_reg <= 8'h00;
         presc_reg <= 16'h0000;
      end else if (ce) begin
         if (state_reg != S_LISTEN || !duty_cycle_switch) begin
            phase_on_reg <= 1'b1;
            duty_cnt_reg <= on_dur_reg;
            presc_reg <= tick_len - 16'h0001;
         end else if (presc_reg != 16'h0000) begin
            presc_reg <= presc_reg - 16'h0001;
         end else begin
            presc_reg <= tick_len - 16'h0001;
            if (duty_cnt_reg <= 8'h01) begin
               phase_on_reg <= !phase_on_reg;
               duty_cnt_reg <= phase_on_reg ? off_dur_reg : on_dur_reg;
            end else begin
               duty_cnt_reg <= duty_cnt_reg - 8'h01;
            end
         end
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= S_IDLE;
         mode_switch_flag <= 1'b0;
         reserved_bit_first <= 1'b0;
         reserved_bit_second <= 1'b0;
         fcs_type_status <= 1'b0;
         whitening_flag <= 1'b0;
         rx_len_reg <= {LEN_W{1'b0}};
         frame_energy_value <= 8'h00;
         hdr_reg <= 16'h0000;
         hdr_cnt_reg <= 5'd0;
         oct_reg <= 8'h00;
         oct_bit_reg <= 3'd0;
         oct_cnt_reg <= {LEN_W{1'b0}};
         len_reg <= {LEN_W{1'b0}};
         raw_frame_reg <= 1'b0;
         pn9_reg <= `FHRR_PN9_SEED;
         rssi_ref_reg <= 8'h00;
         fb_wr_en <= 1'b0;
         fb_wr_addr <= {LEN_W{1'b0}};
         fb_wr_data <= 8'h00;
         frame_start_irq <= 1'b0;
         frame_end <= 1'b0;
         listen_restart <= 1'b0;
         dewhite_active <= 1'b0;
         fcs_eval_en <= 1'b1;
         addr_filter_en <= 1'b1;
         fec_active <= 1'b0;
      end else if (ce) begin
         fb_wr_en <= 1'b0;
         frame_start_irq <= 1'b0;
         frame_end <= 1'b0;
         listen_restart <= 1'b0;
         if (!rx_enable) begin
            state_reg <= S_IDLE;
            dewhite_active <= 1'b0;
         end else if (capt_hit) begin
            state_reg <= S_LISTEN;
            listen_restart <= 1'b1;
            dewhite_active <= 1'b0;
         end else begin
            case (state_reg)
               S_IDLE: begin
                  state_reg <= S_LISTEN;
               end
               S_LISTEN: begin
                  if (frontend_on && corr_val > preamble_thr) begin
                     state_reg <= S_LOCK;
                     rssi_ref_reg <= rssi_dbm;
                  end
               end
               S_LOCK: begin
                  hdr_cnt_reg <= 5'd0;
                  oct_reg <= 8'h00;
                  oct_bit_reg <= 3'd0;
                  oct_cnt_reg <= {LEN_W{1'b0}};
                  pn9_reg <= `FHRR_PN9_SEED;
                  fb_wr_addr <= {LEN_W{1'b0}};
                  if (sync_done) begin
                     raw_frame_reg <= sync_raw;
                     fec_active <= sync_fec;
                     frame_energy_value <= rssi_dbm;
                     if (sync_raw) begin
                        // Length is sampled here, so it must already be set
                        len_reg <= raw_len_reg;
                        dewhite_active <= 1'b0;
                        fcs_eval_en <= 1'b0;
                        addr_filter_en <= 1'b0;
                        if (raw_len_reg == {LEN_W{1'b0}}) begin
                           state_reg <= S_LISTEN;
                        end else begin
                           state_reg <= S_DATA;
                           frame_start_irq <= 1'b1;
                        end
                     end else begin
                        state_reg <= S_HDR;
                     end
                  end else if (corr_val <= preamble_thr) begin
                     state_reg <= S_LISTEN;
                  end
               end
               S_HDR: begin
                  if (bit_valid) begin
                     hdr_reg[hdr_cnt_reg[3:0]] <= bit_data;
                     hdr_cnt_reg <= hdr_cnt_reg + 5'd1;
                     if (hdr_cnt_reg == `FHRR_PHR_BITS - 1) begin
                        hdr_reg <= hdr_full;
                        mode_switch_flag <= hdr_full[`FHRR_PHR_MODE];
                        if (hdr_full[`FHRR_PHR_MODE] && mode_switch_detect_enable) begin
                           // Other status fields left stale, not meaningful here
                           state_reg <= S_MSW;
                           frame_start_irq <= 1'b1;
                           fcs_eval_en <= 1'b0;
                           addr_filter_en <= 1'b0;
                           dewhite_active <= 1'b0;
                        end else begin
                           reserved_bit_first <= hdr_full[`FHRR_PHR_RSV1];
                           reserved_bit_second <= hdr_full[`FHRR_PHR_RSV2];
                           fcs_type_status <= hdr_full[`FHRR_PHR_FCS_TYPE];
                           whitening_flag <= hdr_full[`FHRR_PHR_WHITEN];
                           rx_len_reg <= phr_len;
                           len_reg <= phr_len;
                           fcs_eval_en <= 1'b1;
                           addr_filter_en <= 1'b1;
                           dewhite_active <= hdr_full[`FHRR_PHR_WHITEN];
                           if (phr_len == {LEN_W{1'b0}}) begin
                              state_reg <= S_LISTEN;
                           end else begin
                              state_reg <= S_DATA;
                              frame_start_irq <= 1'b1;
                           end
                        end
                     end
                  end
               end
               S_MSW: begin
                  // Two header octets, one per cycle, in raw bit order
                  fb_wr_en <= 1'b1;
                  fb_wr_addr <= oct_cnt_reg;
                  fb_wr_data <= raw_bit_order_select ? msw_rev : msw_oct;
                  oct_cnt_reg <= oct_cnt_reg + {{(LEN_W-1){1'b0}}, 1'b1};
                  if (oct_cnt_reg != {LEN_W{1'b0}}) begin
                     rx_len_reg <= {{(LEN_W-2){1'b0}}, 2'd2};
                     frame_end <= 1'b1;
                     state_reg <= S_LISTEN;
                  end
               end
               S_DATA: begin
                  if (bit_valid) begin
                     if (dewhite_active) begin
                        pn9_reg <= {pn9_reg[0] ^ pn9_reg[5], pn9_reg[8:1]};
                     end
                     oct_bit_reg <= oct_bit_reg + 3'd1;
                     if (oct_bit_reg == 3'd7) begin
                        oct_reg <= 8'h00;
                        fb_wr_en <= 1'b1;
                        fb_wr_addr <= oct_cnt_reg;
                        fb_wr_data <= (raw_frame_reg && raw_bit_order_select) ?
                                      oct_rev : oct_fill;
                        oct_cnt_reg <= oct_cnt_reg + {{(LEN_W-1){1'b0}}, 1'b1};
                        if (oct_cnt_reg + {{(LEN_W-1){1'b0}}, 1'b1} == len_reg) begin
                           if (raw_frame_reg) begin
                              rx_len_reg <= len_reg;
                           end
                           frame_end <= 1'b1;
                           dewhite_active <= 1'b0;
                           state_reg <= S_LISTEN;
                        end
                     end else begin
                        oct_reg <= oct_fill;
                     end
                  end
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: dv/fhrr_rx_frame_monitor.sv
// Purpose: Port-level checks of the FSK receive frame handler
// Assumes: One clock ref_clk, rst synchronous active high
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module fhrr_rx_frame_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sync_done,
   input wire logic sync_raw,
   input wire logic sync_fec,
   input wire logic preamble_lock,
   input wire logic frontend_on,
   input wire logic rx_state_active,
   input wire logic listen_restart,
   input wire logic frame_end,
   input wire logic fb_wr_en,
   input wire logic dewhite_active,
   input wire logic fcs_eval_en,
   input wire logic addr_filter_en,
   input wire logic fec_active
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_sync_seen;
      sync_done && preamble_lock;
   endsequence
   sequence s_bypass;
      !dewhite_active && !fcs_eval_en && !addr_filter_en;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_lock_on_phase: assert property ($rose(preamble_lock) |-> $past(frontend_on))
      else $error("lock entered outside on phase");
   a_lock_keeps_on: assert property (preamble_lock |-> frontend_on)
      else $error("front end off during lock");
   a_rx_in_off: assert property (!frontend_on |-> rx_state_active)
      else $error("rx state lost in off phase");
   a_restart_listen: assert property (listen_restart |-> !preamble_lock && $past(preamble_lock))
      else $error("restart without leaving lock");
   a_raw_bypass: assert property (s_sync_seen ##0 sync_raw |-> ##[1:2] s_bypass)
      else $error("raw frame kept filters on");
   a_fec_follow: assert property (s_sync_seen |-> ##[1:2] (fec_active == sync_fec))
      else $error("fec state differs from sync decision");
   a_end_with_write: assert property (frame_end |-> fb_wr_en)
      else $error("frame end without buffer write");
   a_dewhite_fcs: assert property (dewhite_active |-> fcs_eval_en && addr_filter_en)
      else $error("de-whitening with filters bypassed");
endmodule
`default_nettype wire

// File: dv/fhrr_fb_model.sv
// Purpose: Host-side frame buffer and interrupt counter model
// Assumes: Buffer writes one octet per pulse on ref_clk
// Notes: Keeps filter flags seen at the last frame start
`timescale 1ns/1ps
`default_nettype none
module fhrr_fb_model (
   input wire logic ref_clk,
   input wire logic fb_wr_en,
   input wire logic [10:0] fb_wr_addr,
   input wire logic [7:0] fb_wr_data,
   input wire logic frame_start_irq,
   input wire logic frame_end,
   input wire logic [2:0] flags
);
   logic [7:0] mem [0:15];
   logic [2:0] wr_flags = 3'h0;
   int irq_cnt = 0;
   int end_cnt = 0;
   // Small window is enough, frames here stay short
   always @(posedge ref_clk) begin
      if (fb_wr_en)
         mem[fb_wr_addr[3:0]] <= fb_wr_data;
      // Flags settle with the start pulse but dewhite_active drops with the last octet
      if (frame_start_irq) begin
         irq_cnt <= irq_cnt + 1;
         wr_flags <= flags;
      end
      if (frame_end)
         end_cnt <= end_cnt + 1;
   end
endmodule
`default_nettype wire

// File: dv/test_fsk_rx_header_raw_rpc.sv
// Purpose: Directed test of header, mode switch, raw, override, duty cycle
// Assumes: BASE_CYC shortened to 2 clocks
// Notes: Status fields of mode switch frames are masked
`timescale 1ns/1ps
`default_nettype none
module test_fsk_rx_header_raw_rpc;
   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic sync_done = 1'b0, sync_raw = 1'b0, sync_fec = 1'b0, bit_valid = 1'b0, bit_data = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [7:0] corr_val = 8'h00, rssi_dbm = 8'hB5;
   wire hreadyout, hresp, fb_wr_en, frame_start_irq, frame_end, listen_restart, frontend_on;
   wire preamble_lock, rx_state_active, dewhite_active, fcs_eval_en, addr_filter_en, fec_active;
   wire [31:0] hrdata;
   wire [10:0] fb_wr_addr;
   wire [7:0] fb_wr_data;
   int fail_count = 0, n_checks = 0, k, n_on, n_off;
   always #4 ref_clk = ~ref_clk;
   fhrr_rx_frame #(.BASE_CYC(2)) dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sync_done(sync_done), .sync_raw(sync_raw), .sync_fec(sync_fec), .bit_valid(bit_valid),
      .bit_data(bit_data), .corr_val(corr_val), .rssi_dbm(rssi_dbm), .fb_wr_en(fb_wr_en),
      .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data), .frame_start_irq(frame_start_irq),
      .frame_end(frame_end), .listen_restart(listen_restart), .frontend_on(frontend_on),
      .preamble_lock(preamble_lock), .rx_state_active(rx_state_active),
      .dewhite_active(dewhite_active), .fcs_eval_en(fcs_eval_en),
      .addr_filter_en(addr_filter_en), .fec_active(fec_active));
   fhrr_fb_model fb (.ref_clk(ref_clk), .fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr),
      .fb_wr_data(fb_wr_data), .frame_start_irq(frame_start_irq), .frame_end(frame_end),
      .flags({dewhite_active, fcs_eval_en, addr_filter_en}));
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic bits(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         bit_valid <= 1'b1;
         bit_data <= v[i];
         @(posedge ref_clk);
         bit_valid <= 1'b0;
      end
   endtask
   task automatic lock_wait();
      corr_val <= 8'h80;
      for (int i = 0; i < 300 && preamble_lock !== 1'b1; i++)
         @(posedge ref_clk);
   endtask
   // Correlation stays high through the frame; a drop before sync would send lock back to listening
   task automatic frame(input logic raw, input logic [15:0] h, input logic [15:0] d, input int n);
      lock_wait();
      @(posedge ref_clk);
      sync_done <= 1'b1;
      sync_raw <= raw;
      sync_fec <= raw;
      @(posedge ref_clk);
      sync_done <= 1'b0;
      if (!raw)
         bits(h, 16);
      bits(d, n);
      repeat (3) @(posedge ref_clk);
      corr_val <= 8'h00;
      repeat (3) @(posedge ref_clk);
   endtask
   // First header bit at index 0, length sent MSB first
   function automatic logic [15:0] hdr(input logic [4:0] f, input logic [10:0] len);
      hdr[4:0] = f;
      for (int i = 0; i < 11; i++)
         hdr[15 - i] = len[i];
   endfunction
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (frontend_on === lvl && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      // Clock enable low: the write must not land
      ce <= 1'b0;
      bus(1, 8'h08, 32'h5);
      ce <= 1'b1;
      bus(0, 8'h08, 0);
      check(rd, 1);
      bus(0, 8'h00, 0);
      check(rd, 32'h00400004);
      bus(1, 8'h20, 32'hFFFFFFFF);
      bus(0, 8'h20, 0);
      check(rd, 0);
      bus(0, 8'h0C, 0);
      check(rd, 1);
      bus(1, 8'h00, 32'h00400104);
      frame(0, hdr(5'b01010, 2), 16'h3CA5, 16);
      check(fb.mem[0], 8'hA5);
      check(fb.mem[1], 8'h3C);
      check(fb.wr_flags, 3'b011);
      check(fb.irq_cnt, 1);
      bus(0, 8'h10, 0);
      check(rd, 32'h0A);
      bus(0, 8'h14, 0);
      check(rd, 2);
      bus(0, 8'h18, 0);
      check(rd, 8'hB5);
      frame(0, hdr(5'b00000, 0), 0, 0);
      check(fb.irq_cnt, 1);
      bus(1, 8'h00, 32'h00400115);
      frame(0, 16'hB2C7, 0, 0);
      check(fb.mem[0], 8'hE3);
      check(fb.mem[1], 8'h4D);
      check(fb.wr_flags, 3'b000);
      check(fb.end_cnt, 2);
      bus(0, 8'h10, 0);
      check(rd & 32'h1, 1);
      bus(0, 8'h14, 0);
      check(rd, 2);
      // Zero payload whitened by a seed of all ones gives all ones
      frame(0, hdr(5'b10000, 1), 0, 8);
      check(fb.mem[0], 8'hFF);
      check(fb.wr_flags, 3'b111);
      bus(0, 8'h10, 0);
      check(rd, 32'h10);
      bus(1, 8'h04, 2);
      k = fb.irq_cnt;
      frame(1, 0, 16'h0301, 16);
      check(fb.mem[0], 8'h80);
      check(fb.mem[1], 8'hC0);
      check(fb.wr_flags, 3'b000);
      check(fb.irq_cnt, k + 1);
      for (int l = 0; l < 4; l++) begin
         bus(1, 8'h00, 32'h00400100 | (32'(l) << 1));
         for (int j = 0; j < 2; j++) begin
            rssi_dbm <= 8'hC4;
            lock_wait();
            @(posedge ref_clk);
            rssi_dbm <= 8'(8'hC4 + 6 * (l + 1) + j);
            k = 0;
            repeat (4) begin
               @(posedge ref_clk);
               if (listen_restart === 1'b1)
                  k = 1;
            end
            check(k, l < 3 && j == 1);
            corr_val <= 8'h00;
            repeat (3) @(posedge ref_clk);
         end
      end
      bus(1, 8'h08, 2);
      bus(1, 8'h0C, 3);
      for (int b = 0; b < 2; b++) begin
         bus(1, 8'h00, 32'h0040010C | (32'(b) << 5));
         // Skip phases begun before the new base time took effect
         run_len(0, n_off);
         run_len(1, n_on);
         run_len(0, n_off);
         run_len(1, n_on);
         check(n_off, 3 * (2 << b));
         check(n_on, 2 * (2 << b));
      end
      lock_wait();
      k = 0;
      repeat (40) begin
         @(posedge ref_clk);
         if (frontend_on !== 1'b1)
            k++;
      end
      check(k, 0);
      corr_val <= 8'h00;
      conclude();
   end
   initial begin
      #(8 * 30000);
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
bind fhrr_rx_frame fhrr_rx_frame_monitor mon (.ref_clk(ref_clk), .rst(rst),
   .hreadyout(hreadyout), .hresp(hresp), .sync_done(sync_done), .sync_raw(sync_raw),
   .sync_fec(sync_fec), .preamble_lock(preamble_lock), .frontend_on(frontend_on),
   .rx_state_active(rx_state_active), .listen_restart(listen_restart), .frame_end(frame_end),
   .fb_wr_en(fb_wr_en), .dewhite_active(dewhite_active), .fcs_eval_en(fcs_eval_en),
   .addr_filter_en(addr_filter_en), .fec_active(fec_active));
`default_nettype wire
